// ---- pcs_tx_defs.svh ----
// Purpose: constants for the gigabit transmit symbol encoder
// Assumes: one 100 MHz clock, one symbol per enabled cycle
// Notes:   definitions only
`ifndef PCS_TX_DEFS_SVH
`define PCS_TX_DEFS_SVH
`define LFSR_W        33
`define LFSR_TAP_M    12
`define LFSR_TAP_S    19
`define LFSR_TOP      32
`define LFSR_SEED     33'h1_5A5A_A5A5
`define MODE_SEND_Z   2'h0
`define MODE_SEND_I   2'h1
`define MODE_SEND_N   2'h2
`define SYM_RATE_MHZ  125
`define CLK_MHZ       100
`define PR_W          5
`define CNT_W         8
`endif

// ---- pcs_tx_pkg.sv ----
// Purpose: types shared by the transmit symbol encoder files
// Assumes: nothing
// Notes:   symbols are signed, -2..+2; shaped codes are -8..+8 quarter steps
package pcs_tx_pkg;
  typedef enum logic [1:0] {
    SEND_Z = 2'h0,
    SEND_I = 2'h1,
    SEND_N = 2'h2
  } tx_mode_t;
  typedef logic signed [2:0] pam5_t;
  typedef logic signed [4:0] pam17_t;
  typedef struct packed {
    pam5_t a;
    pam5_t b;
    pam5_t c;
    pam5_t d;
  } quartet_t;
  typedef struct packed {
    pam17_t a;
    pam17_t b;
    pam17_t c;
    pam17_t d;
  } dac_word_t;
  typedef struct packed {
    logic [3:0] sx;
    logic [3:0] sy;
    logic [3:0] sg;
  } scr_words_t;
endpackage

// ---- pcs_tx_lfsr.sv ----
// Purpose: side-stream scrambler shift register
// Assumes: adv pulses once per symbol
// Notes:   seed is nonzero, all-zero state can never be reached
`timescale 1ns/100ps
`include "pcs_tx_defs.svh"
module pcs_tx_lfsr (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // control
  input  wire logic                adv,
  input  wire logic                master,
  // state out
  output logic [`LFSR_W-1:0]       scr
);
  typedef struct packed {
    logic [`LFSR_W-1:0] sr;
  } lfsr_state_t;
  lfsr_state_t st_ff;
  lfsr_state_t nxt_st;
  logic        fb;
  always_comb begin
    nxt_st = st_ff;
    fb = st_ff.sr[`LFSR_TOP] ^
         (master ? st_ff.sr[`LFSR_TAP_M] : st_ff.sr[`LFSR_TAP_S]);
    if (adv) begin
      nxt_st.sr = {st_ff.sr[`LFSR_W-2:0], fb};
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{sr: `LFSR_SEED};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign scr = st_ff.sr;
  property p_no_lockup;
    @(posedge clk) disable iff (rst) st_ff.sr != '0;
  endproperty
  a_no_lockup: assert property (p_no_lockup) else $error("lfsr locked at zero");
  property p_shift;
    @(posedge clk) disable iff (rst)
      adv |=> st_ff.sr[`LFSR_W-1:1] == $past(st_ff.sr[`LFSR_W-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("lfsr did not shift");
  property p_taps;
    @(posedge clk) disable iff (rst)
      adv |=> st_ff.sr[0] == ($past(st_ff.sr[`LFSR_TOP]) ^ ($past(master) ?
        $past(st_ff.sr[`LFSR_TAP_M]) : $past(st_ff.sr[`LFSR_TAP_S])));
  endproperty
  a_taps: assert property (p_taps) else $error("lfsr feedback wrong");
endmodule // pcs_tx_lfsr

// ---- pcs_tx_mapper.sv ----
// Purpose: 9-bit word to PAM-5 quartet mapping, even and odd subsets
// Assumes: combinational, registered by the caller
// Notes:   bit 8 with bits 7:6 selects the odd subsets; low three bit pairs pick values
`timescale 1ns/100ps
module pcs_tx_mapper (
  // input word
  input  wire logic [8:0]          sd,
  // symbols
  output pcs_tx_pkg::quartet_t     sym
);
  // one-dimensional subset points: x even {-2,0,+2}, y odd {-1,+1}
  function automatic pcs_tx_pkg::pam5_t pick(input logic odd, input logic [1:0] v);
    pcs_tx_pkg::pam5_t r;
    r = 3'sh0;
    if (odd) begin
      r = v[0] ? 3'sh1 : 3'sh7;
    end else begin
      case (v)
        2'h0:    r = 3'sh0;
        2'h1:    r = 3'sh2;
        2'h2:    r = 3'sh6;
        default: r = 3'sh0;
      endcase
    end
    return r;
  endfunction
  logic [3:0] odd;
  always_comb begin
    // subset choice per pair from the parity bit and data bits 7:6
    odd = {sd[8], sd[8] ^ sd[7], sd[8] ^ sd[6], sd[8] ^ sd[7] ^ sd[6]};
    sym.a = pick(odd[3], sd[1:0]);
    sym.b = pick(odd[2], sd[3:2]);
    sym.c = pick(odd[1], sd[5:4]);
    sym.d = pick(odd[0], {sd[7], sd[6] ^ sd[0]});
  end
endmodule // pcs_tx_mapper

// ---- pcs_tx_encoder.sv ----
// Purpose: 1000BASE-T style transmit coding path, GMII byte in, 17-level codes out
// Assumes: sym_en pulses once per symbol period; tx_mode and tx_enable held by
//          the startup controller and enable state machine
// Notes:   codes are quarter steps of the PAM-5 unit, range -8..+8
`timescale 1ns/100ps
`include "pcs_tx_defs.svh"
module pcs_tx_encoder (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // control from startup and enable logic
  input  wire logic                 master,
  input  pcs_tx_pkg::tx_mode_t      tx_mode,
  input  wire logic                 tx_enable,
  input  wire logic                 sym_en,
  // gmii transmit byte
  input  wire logic [7:0]           txd,
  // dac codes
  output pcs_tx_pkg::dac_word_t     dac,
  output logic                      dac_valid
);
  typedef struct packed {
    logic [2:0]            cs;      // trellis state
    logic [1:0]            cs_d;    // delayed state fed back
    pcs_tx_pkg::quartet_t  prev;    // previous scrambled symbols
    pcs_tx_pkg::dac_word_t dac;
    logic                  vld;
  } enc_state_t;
  enc_state_t st_ff;
  enc_state_t nxt_st;
  logic [`LFSR_W-1:0]    scr;
  pcs_tx_pkg::scr_words_t w;
  logic [7:0]            sc;
  logic [7:0]            sd;
  logic                  par;
  logic [3:0]            sgn;
  pcs_tx_pkg::quartet_t  tsym;
  pcs_tx_pkg::quartet_t  ssym;
  // lfsr steps only on symbol strobes, so state is one per symbol
  pcs_tx_lfsr u_lfsr (
    .clk    (clk),
    .rst    (rst),
    .adv    (sym_en),
    .master (master),
    .scr    (scr)
  );
  // word generator: xor combinations of the side stream
  always_comb begin
    w.sx = {scr[3] ^ scr[8], scr[2] ^ scr[7], scr[1] ^ scr[6], scr[0]};
    w.sy = {scr[3] ^ scr[12], scr[2] ^ scr[9], scr[1] ^ scr[5], scr[4]};
    w.sg = {scr[8] ^ scr[20], scr[6] ^ scr[16], scr[3] ^ scr[14], scr[1] ^ scr[11]};
  end
  // bit generator: zeros mode blanks the stream, normal mode without enable swaps low word bits into the top nibble
  always_comb begin
    sc = 8'h00;
    case (tx_mode)
      pcs_tx_pkg::SEND_Z: sc = 8'h00;
      pcs_tx_pkg::SEND_I: sc = {w.sx[3:2], w.sy[3:2], w.sx[1:0], w.sy[1:0]};
      pcs_tx_pkg::SEND_N: begin
        sc[7:4] = tx_enable ? {w.sx[3:2], w.sy[3:2]} : {w.sy[0], w.sx[0], w.sy[1], w.sx[1]};
        sc[3:0] = {w.sx[1:0], w.sy[1:0]};
      end
      default: sc = 8'h00;
    endcase
  end
  // data scrambler: data only while enabled in normal mode
  always_comb begin
    if (tx_mode == pcs_tx_pkg::SEND_N && tx_enable) begin
      sd = txd ^ sc;
    end else begin
      sd = sc;
    end
    // outside data, the delayed encoder state reshapes the top pair for the current symbol
    sd[7:6] = sd[7:6] ^ (tx_enable ? 2'h0 : st_ff.cs_d);
  end
  // convolutional encoder parity, forced low outside data
  assign par = tx_enable ? st_ff.cs[0] : 1'b0;
  pcs_tx_mapper u_map (
    .sd  ({par, sd}),
    .sym (tsym)
  );
  // sign generator: idle keeps raw signs, data rotates them
  assign sgn = tx_enable ? {w.sg[0], w.sg[3:1]} : w.sg;
  always_comb begin
    ssym.a = sgn[3] ? -tsym.a : tsym.a;
    ssym.b = sgn[2] ? -tsym.b : tsym.b;
    ssym.c = sgn[1] ? -tsym.c : tsym.c;
    ssym.d = sgn[0] ? -tsym.d : tsym.d;
  end
  // 3*cur + prev in quarter steps: -8..+8, 17 levels in 5 signed bits
  function automatic pcs_tx_pkg::pam17_t shape(input pcs_tx_pkg::pam5_t c,
                                               input pcs_tx_pkg::pam5_t p);
    pcs_tx_pkg::pam17_t cx;
    pcs_tx_pkg::pam17_t px;
    cx = `PR_W'(c);
    px = `PR_W'(p);
    return (cx <<< 1) + cx + px;
  endfunction
  always_comb begin
    nxt_st = st_ff;
    nxt_st.vld = sym_en;
    if (sym_en) begin
      nxt_st.cs = {sd[6] ^ st_ff.cs[0], sd[7] ^ st_ff.cs[2], st_ff.cs[1]};
      nxt_st.cs_d = st_ff.cs[1:0];
      nxt_st.prev = ssym;
      nxt_st.dac.a = shape(ssym.a, st_ff.prev.a);
      nxt_st.dac.b = shape(ssym.b, st_ff.prev.b);
      nxt_st.dac.c = shape(ssym.c, st_ff.prev.c);
      nxt_st.dac.d = shape(ssym.d, st_ff.prev.d);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // one code per strobe; sym_en held high gives at most 100 MHz symbols, short of the 125 MHz rate
  assign dac = st_ff.dac;
  assign dac_valid = st_ff.vld;

  property p_zero_mode;
    @(posedge clk) disable iff (rst)
      sym_en && tx_mode == pcs_tx_pkg::SEND_Z && !tx_enable && st_ff.cs_d == 2'h0 |-> sd == 8'h00;
  endproperty
  a_zero_mode: assert property (p_zero_mode) else $error("zeros mode not zero");
  property p_data_xor;
    @(posedge clk) disable iff (rst)
      tx_mode == pcs_tx_pkg::SEND_N && tx_enable |-> sd == (txd ^ sc);
  endproperty
  a_data_xor: assert property (p_data_xor) else $error("data scramble wrong");
  property p_parity_idle;
    @(posedge clk) disable iff (rst) !tx_enable |-> !par;
  endproperty
  a_parity_idle: assert property (p_parity_idle) else $error("parity set outside data");
  property p_cs_delay;
    @(posedge clk) disable iff (rst)
      sym_en |=> st_ff.cs_d == $past(st_ff.cs[1:0]);
  endproperty
  a_cs_delay: assert property (p_cs_delay) else $error("state delay wrong");
  property p_sign;
    @(posedge clk) disable iff (rst)
      sgn[3] |-> ssym.a == -tsym.a;
  endproperty
  a_sign: assert property (p_sign) else $error("sign not applied");
  property p_shape;
    @(posedge clk) disable iff (rst)
      sym_en ##1 sym_en |=> dac.a == 3 * $past(ssym.a) + $past(ssym.a, 2);
  endproperty
  a_shape: assert property (p_shape) else $error("shaping wrong");
  property p_range;
    @(posedge clk) disable iff (rst)
      dac.a >= -5'sh8 && dac.a <= 5'sh8 && dac.d >= -5'sh8 && dac.d <= 5'sh8;
  endproperty
  a_range: assert property (p_range) else $error("code out of range");
  property p_valid;
    @(posedge clk) disable iff (rst) sym_en |=> dac_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("code not issued");

  // shaping, signs and range on the remaining pairs, plus the unflipped sign on a
  property p_shape_b;
    @(posedge clk) disable iff (rst)
      sym_en ##1 sym_en |=> dac.b == 3 * $past(ssym.b) + $past(ssym.b, 2);
  endproperty
  a_shape_b: assert property (p_shape_b) else $error("shaping wrong on b");
  property p_shape_c;
    @(posedge clk) disable iff (rst)
      sym_en ##1 sym_en |=> dac.c == 3 * $past(ssym.c) + $past(ssym.c, 2);
  endproperty
  a_shape_c: assert property (p_shape_c) else $error("shaping wrong on c");
  property p_shape_d;
    @(posedge clk) disable iff (rst)
      sym_en ##1 sym_en |=> dac.d == 3 * $past(ssym.d) + $past(ssym.d, 2);
  endproperty
  a_shape_d: assert property (p_shape_d) else $error("shaping wrong on d");
  property p_sign_b;
    @(posedge clk) disable iff (rst)
      sgn[2] |-> ssym.b == -tsym.b;
  endproperty
  a_sign_b: assert property (p_sign_b) else $error("sign not applied on b");
  property p_sign_c;
    @(posedge clk) disable iff (rst)
      sgn[1] |-> ssym.c == -tsym.c;
  endproperty
  a_sign_c: assert property (p_sign_c) else $error("sign not applied on c");
  property p_sign_d;
    @(posedge clk) disable iff (rst)
      sgn[0] |-> ssym.d == -tsym.d;
  endproperty
  a_sign_d: assert property (p_sign_d) else $error("sign not applied on d");
  property p_keep_a;
    @(posedge clk) disable iff (rst)
      !sgn[3] |-> ssym.a == tsym.a;
  endproperty
  a_keep_a: assert property (p_keep_a) else $error("sign flipped without cause");
  property p_range_bc;
    @(posedge clk) disable iff (rst)
      dac.b >= -5'sh8 && dac.b <= 5'sh8 && dac.c >= -5'sh8 && dac.c <= 5'sh8;
  endproperty
  a_range_bc: assert property (p_range_bc) else $error("code out of range on b or c");

  // between strobes codes and state hold and valid drops; on strobes lfsr and prev advance
  property p_hold;
    @(posedge clk) disable iff (rst)
      !sym_en |=> $stable(dac);
  endproperty
  a_hold: assert property (p_hold) else $error("code changed without strobe");
  property p_valid_low;
    @(posedge clk) disable iff (rst)
      !sym_en |=> !dac_valid;
  endproperty
  a_valid_low: assert property (p_valid_low) else $error("valid without strobe");
  property p_scr_hold;
    @(posedge clk) disable iff (rst)
      !sym_en |=> $stable(scr);
  endproperty
  a_scr_hold: assert property (p_scr_hold) else $error("lfsr moved without strobe");
  property p_scr_step;
    @(posedge clk) disable iff (rst)
      sym_en |=> scr != $past(scr);
  endproperty
  a_scr_step: assert property (p_scr_step) else $error("lfsr did not advance");
  property p_cs_hold;
    @(posedge clk) disable iff (rst)
      !sym_en |=> $stable(st_ff.cs) && $stable(st_ff.cs_d);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("trellis state moved");
  property p_prev;
    @(posedge clk) disable iff (rst)
      sym_en |=> st_ff.prev == $past(ssym);
  endproperty
  a_prev: assert property (p_prev) else $error("previous symbol not kept");

  // mode and enable effects on the coding words
  property p_sc_zero;
    @(posedge clk) disable iff (rst)
      tx_mode == pcs_tx_pkg::SEND_Z |-> sc == 8'h00;
  endproperty
  a_sc_zero: assert property (p_sc_zero) else $error("zeros mode stream not blank");
  property p_idle_sd;
    @(posedge clk) disable iff (rst)
      !tx_enable |-> sd[5:0] == sc[5:0];
  endproperty
  a_idle_sd: assert property (p_idle_sd) else $error("idle word not from stream");
  property p_par_data;
    @(posedge clk) disable iff (rst)
      tx_enable |-> par == st_ff.cs[0];
  endproperty
  a_par_data: assert property (p_par_data) else $error("parity not from state");
  property p_zero_sym;
    @(posedge clk) disable iff (rst)
      tx_mode == pcs_tx_pkg::SEND_Z && !tx_enable && st_ff.cs_d == 2'h0 |-> tsym == '0;
  endproperty
  a_zero_sym: assert property (p_zero_sym) else $error("zeros mode symbols not zero");
  property p_top_idle;
    @(posedge clk) disable iff (rst)
      !tx_enable |-> sd[7:6] == (sc[7:6] ^ st_ff.cs_d);
  endproperty
  a_top_idle: assert property (p_top_idle) else $error("delayed state not fed back");
  property p_sgn_idle;
    @(posedge clk) disable iff (rst)
      !tx_enable |-> sgn == w.sg;
  endproperty
  a_sgn_idle: assert property (p_sgn_idle) else $error("idle signs altered");

  c_data: cover property (@(posedge clk) disable iff (rst)
    tx_mode == pcs_tx_pkg::SEND_N && tx_enable && sym_en);
  c_idle: cover property (@(posedge clk) disable iff (rst)
    tx_mode == pcs_tx_pkg::SEND_I && sym_en);
  c_peak: cover property (@(posedge clk) disable iff (rst) dac.a == 5'sh8);
  c_gap: cover property (@(posedge clk) disable iff (rst)
    sym_en ##1 !sym_en ##1 sym_en);
  c_slave: cover property (@(posedge clk) disable iff (rst)
    !master && tx_enable && sym_en);
endmodule // pcs_tx_encoder

// ---- pcs_mac_model.sv ----
// Purpose: gigabit mac stand-in driving the transmit byte and frame enable
// Assumes: bytes advance only on symbol strobes
// Notes:   outside a frame the byte lines flip each strobe without go, so the last frame byte returns every second strobe
`timescale 1ns/100ps
module pcs_mac_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control from bench
  input  wire logic       sym_en,
  input  wire logic       go,
  input  wire logic [7:0] len,
  // gmii transmit side
  output logic      [7:0] txd,
  output logic            tx_enable
);
  logic [7:0] left_ff;
  logic [7:0] cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_ff   <= 8'h00;
      cnt_ff    <= 8'h00;
      txd       <= 8'h00;
      tx_enable <= 1'b0;
    end else if (go) begin
      left_ff <= len;
    end else if (sym_en) begin
      tx_enable <= (left_ff != 8'h00);
      txd       <= (left_ff != 8'h00) ? (8'hA5 ^ cnt_ff) : ~txd;
      if (left_ff != 8'h00) begin
        left_ff <= left_ff - 8'h01;
        cnt_ff  <= cnt_ff + 8'h01;
      end
    end
  end
endmodule // pcs_mac_model

// ---- gigabit_pcs_tx_symbol_encoder_tb_top.sv ----
// Purpose: self-checking bench for the transmit symbol encoder
// Assumes: scrambler details are unknown, so shaping is checked by level algebra
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module gigabit_pcs_tx_symbol_encoder_tb_top;
  localparam pcs_tx_pkg::tx_mode_t MZ = pcs_tx_pkg::SEND_Z;
  localparam pcs_tx_pkg::tx_mode_t MI = pcs_tx_pkg::SEND_I;
  localparam pcs_tx_pkg::tx_mode_t MN = pcs_tx_pkg::SEND_N;
  typedef struct {logic se; pcs_tx_pkg::tx_mode_t md; logic go; logic ev;} row_t;
  logic                  clk, rst, master, tx_enable, sym_en, go, dac_valid;
  pcs_tx_pkg::tx_mode_t  tx_mode;
  logic [7:0]            txd;
  pcs_tx_pkg::dac_word_t dac;
  logic [19:0]           held;
  logic [4:0]            lane_mask [4];
  logic [19:0]           log_q [$];
  logic [19:0]           seq_a [$];
  logic [19:0]           seq_b [$];
  int                    mismatches, samples_checked, cycles;
  row_t                  rows [10];

  pcs_mac_model pcs_mac_model_i (.clk(clk), .rst(rst), .sym_en(sym_en), .go(go),
    .len(8'h06), .txd(txd), .tx_enable(tx_enable));
  pcs_tx_encoder pcs_tx_encoder_i (.clk(clk), .rst(rst), .master(master),
    .tx_mode(tx_mode), .tx_enable(tx_enable), .sym_en(sym_en), .txd(txd),
    .dac(dac), .dac_valid(dac_valid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a ceiling well above the roughly 110 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // keeps the set of symbols that could stand behind each code seen so far
  function automatic logic [4:0] nxt_mask(logic [4:0] m, logic signed [4:0] code);
    logic [4:0] r;
    r = 5'h00;
    for (int c = -2; c <= 2; c++)
      for (int p = -2; p <= 2; p++)
        if (m[p+2] && (3 * c + p) == code) r[c+2] = 1'b1;
    return r;
  endfunction

  // element by element with case equality, so unknown bits must match exactly
  function automatic bit same_codes(input logic [19:0] x [$], input logic [19:0] y [$]);
    bit r;
    r = (x.size() == y.size());
    if (r)
      foreach (x[i]) if (x[i] !== y[i]) r = 1'b0;
    return r;
  endfunction

  task automatic do_reset();
    rst = 1'b1;
    sym_en = 1'b0;
    go = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check("dac_in_reset", dac, 0);
    check("valid_in_reset", dac_valid, 0);
    rst = 1'b0;
    held = 20'h00000;
    for (int i = 0; i < 4; i++) lane_mask[i] = 5'h1F;
  endtask

  task automatic step(input logic se, input pcs_tx_pkg::tx_mode_t md, input logic g,
                      input logic ev);
    logic signed [4:0] code [4];
    sym_en = se;
    tx_mode = md;
    go = g;
    @(posedge clk);
    #1;
    check("dac_valid", dac_valid, ev);
    if (dac_valid === 1'b1) begin
      code = '{dac.a, dac.b, dac.c, dac.d};
      for (int i = 0; i < 4; i++) begin
        lane_mask[i] = nxt_mask(lane_mask[i], code[i]);
        check("shape_level", lane_mask[i] != 5'h00, 1);
      end
      held = dac;
      log_q.push_back(dac);
    end else begin
      check("dac_hold", dac, held);
    end
  endtask

  // strobes with or without idle gaps must give the same codes
  task automatic run_seq(input logic m, input bit gap);
    master = m;
    do_reset();
    log_q.delete();
    step(1'b1, MN, 1'b1, 1'b1);
    repeat (11) begin
      if (gap) step(1'b0, MN, 1'b0, 1'b0);
      step(1'b1, MN, 1'b0, 1'b1);
    end
  endtask

  initial begin
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    master = 1'b1;
    tx_mode = MZ;
    rows = '{'{1'b1, MZ, 1'b0, 1'b1}, '{1'b1, MI, 1'b0, 1'b1}, '{1'b0, MI, 1'b0, 1'b0},
             '{1'b1, MN, 1'b1, 1'b1}, '{1'b1, MN, 1'b0, 1'b1}, '{1'b1, MN, 1'b0, 1'b1},
             '{1'b0, MN, 1'b0, 1'b0}, '{1'b1, MN, 1'b0, 1'b1}, '{1'b1, MI, 1'b0, 1'b1},
             '{1'b1, MZ, 1'b0, 1'b1}};
    do_reset();
    foreach (rows[i]) step(rows[i].se, rows[i].md, rows[i].go, rows[i].ev);
    run_seq(1'b1, 1'b0);
    seq_a = log_q;
    run_seq(1'b1, 1'b1);
    seq_b = log_q;
    check("reseed_repeat", same_codes(seq_a, seq_b), 1);
    run_seq(1'b0, 1'b0);
    check("slave_differs", same_codes(seq_a, log_q), 0);
    // two zero symbols in a row leave nothing for the shaper to carry
    do_reset();
    step(1'b1, MZ, 1'b0, 1'b1);
    step(1'b1, MZ, 1'b0, 1'b1);
    check("zeros_mode", dac, 0);
    finish_test();
  end
endmodule // gigabit_pcs_tx_symbol_encoder_tb_top
